// *** vftc_top.v ***
// per-field vertical filter, line pulse timing and soft reset behind an ahb-lite slave
// What this block does
// - pulse select clear: line pulse lasts 64 pixel clocks
// - pulse select set: line pulse lasts one pixel period
// - later variant, select set: line pulse lasts 32 pixel clocks
// - separate even and odd timing control registers at 0x6C and 0xEC
// - both timing registers reset to zero; tap field starts at bit zero
// - comb set: binomial filters of two to five taps
// - comb clear: interpolation only, or binomial prefilter then two-tap interpolation
// - soft reset register writable at any time
// - soft reset register reads zero
// - any write to 0x07C returns all registers to defaults
`timescale 1ns/1ps
`default_nettype none
`include "vftc_map.vh"

module vftc_top (
    input wire CLOCK,
    input wire NRST,
    input wire HSEL,
    input wire [31:0] HADDR,
    input wire [1:0] HTRANS,
    input wire HWRITE,
    input wire [2:0] HSIZE,
    input wire [31:0] HWDATA,
    input wire HREADY,
    output reg [31:0] HRDATA,
    output wire HREADYOUT,
    output wire HRESP,
    input wire PIXEL_CE,
    input wire FIELD_ODD,
    input wire LINE_START,
    input wire PIX_VALID,
    input wire [7:0] PIX_DATA,
    input wire [3:0] VERT_PHASE,
    output reg OUT_VALID,
    output reg [7:0] OUT_DATA,
    output reg HORIZ_LINE_PULSE
);

    reg [7:0] even_field_timing_ctl;
    reg [7:0] odd_field_timing_ctl;
    reg [7:0] even_vert_scale_upper;
    reg [7:0] odd_vert_scale_upper;
    reg [7:0] variant_cfg;
    reg dp_write;
    reg [`VFTC_ADDR_W-1:0] dp_addr;
    reg [6:0] pulse_left;
    reg [`VFTC_COL_W-1:0] col;
    reg [2:0] lines_seen;
    reg field_last;
    reg [7:0] lb0 [0:`VFTC_LINE_DEPTH-1];
    reg [7:0] lb1 [0:`VFTC_LINE_DEPTH-1];
    reg [7:0] lb2 [0:`VFTC_LINE_DEPTH-1];
    reg [7:0] lb3 [0:`VFTC_LINE_DEPTH-1];

    wire [`VFTC_ADDR_W-1:0] ap_addr;
    wire ap_take;
    wire soft_reset;
    wire [7:0] tc_active;
    wire [7:0] su_active;
    wire [1:0] vert_tap_select;
    wire vert_comb_select;
    wire hpulse_width_select;
    wire pixel_clock_single;
    wire [6:0] pulse_width;
    wire [7:0] t0;
    wire [7:0] t1;
    wire [7:0] t2;
    wire [7:0] t3;
    wire [7:0] t4;
    wire [7:0] filtered;
    reg [31:0] next_rdata;

    // zero wait state, always okay
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
    assign ap_addr = HADDR[`VFTC_ADDR_W-1:0];
    assign ap_take = HSEL && HREADY && HTRANS[1];
    assign soft_reset = dp_write && (dp_addr == `VFTC_OFS_SOFT_RESET_CMD);
    // soft reset clears registers only; line history and a running pulse carry on

    assign pixel_clock_single = PIXEL_CE;
    assign tc_active = FIELD_ODD ? odd_field_timing_ctl : even_field_timing_ctl;
    assign su_active = FIELD_ODD ? odd_vert_scale_upper : even_vert_scale_upper;
    assign vert_tap_select = tc_active[`VFTC_TC_TAP_MSB:`VFTC_TC_TAP_LSB];
    assign vert_comb_select = su_active[`VFTC_SU_COMB_BIT];
    assign hpulse_width_select = tc_active[`VFTC_TC_PULSE_SEL_BIT];
    assign pulse_width = !hpulse_width_select ? `VFTC_PULSE_LONG :
        (variant_cfg[`VFTC_VAR_LATER_BIT] ? `VFTC_PULSE_MID : `VFTC_PULSE_SHORT);

    // register file; bus write data is taken in the data phase
    always @(posedge CLOCK) begin
        if (!NRST || soft_reset) begin
            even_field_timing_ctl <= `VFTC_TC_RESET;
            odd_field_timing_ctl <= `VFTC_TC_RESET;
            even_vert_scale_upper <= `VFTC_SU_RESET;
            odd_vert_scale_upper <= `VFTC_SU_RESET;
            variant_cfg <= `VFTC_VAR_RESET;
        end else if (dp_write) begin
            case (dp_addr)
                `VFTC_OFS_EVEN_TIMING_CTL: begin
                    even_field_timing_ctl <= HWDATA[7:0] & `VFTC_TC_WMASK;
                end
                `VFTC_OFS_ODD_TIMING_CTL: begin
                    odd_field_timing_ctl <= HWDATA[7:0] & `VFTC_TC_WMASK;
                end
                `VFTC_OFS_EVEN_SCALE_UPPER: begin
                    even_vert_scale_upper <= HWDATA[7:0] & `VFTC_SU_WMASK;
                end
                `VFTC_OFS_ODD_SCALE_UPPER: begin
                    odd_vert_scale_upper <= HWDATA[7:0] & `VFTC_SU_WMASK;
                end
                `VFTC_OFS_VARIANT_CFG: begin
                    variant_cfg <= {7'h00, HWDATA[`VFTC_VAR_LATER_BIT]};
                end
                default: begin
                    variant_cfg <= variant_cfg;
                end
            endcase
        end
    end

    // address phase capture
    always @(posedge CLOCK) begin
        if (!NRST) begin
            dp_write <= 1'b0;
            dp_addr <= 12'h000;
        end else if (HREADY) begin
            dp_write <= ap_take && HWRITE;
            dp_addr <= ap_addr;
        end
    end

    // read data registered at the address phase so it stands through the data phase
    always @* begin
        next_rdata = 32'h0000_0000;
        case (ap_addr)
            `VFTC_OFS_EVEN_TIMING_CTL: next_rdata[7:0] = even_field_timing_ctl;
            `VFTC_OFS_ODD_TIMING_CTL: next_rdata[7:0] = odd_field_timing_ctl;
            `VFTC_OFS_EVEN_SCALE_UPPER: next_rdata[7:0] = even_vert_scale_upper;
            `VFTC_OFS_ODD_SCALE_UPPER: next_rdata[7:0] = odd_vert_scale_upper;
            `VFTC_OFS_VARIANT_CFG: next_rdata[7:0] = variant_cfg;
            `VFTC_OFS_STATUS: begin
                next_rdata[`VFTC_ST_PULSE_BIT] = HORIZ_LINE_PULSE;
                next_rdata[`VFTC_ST_FIELD_BIT] = FIELD_ODD;
                next_rdata[`VFTC_ST_COMB_BIT] = vert_comb_select;
                next_rdata[`VFTC_ST_TAP_LSB+1:`VFTC_ST_TAP_LSB] = vert_tap_select;
                next_rdata[`VFTC_ST_LINES_LSB+2:`VFTC_ST_LINES_LSB] = lines_seen;
            end
            // soft reset command reads zero; software must not rely on it
            `VFTC_OFS_SOFT_RESET_CMD: next_rdata = 32'h0000_0000;
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    always @(posedge CLOCK) begin
        if (!NRST) begin
            HRDATA <= 32'h0000_0000;
        end else if (ap_take && !HWRITE) begin
            // a read right behind a write to the same register still sees the old value
            HRDATA <= next_rdata;
        end
    end

    // line pulse, counted in pixel clock enables
    always @(posedge CLOCK) begin
        if (!NRST) begin
            HORIZ_LINE_PULSE <= 1'b0;
            pulse_left <= 7'h00;
        end else if (pixel_clock_single) begin
            if (LINE_START) begin
                HORIZ_LINE_PULSE <= 1'b1;
                // a line start inside a pulse restarts it at the width of the field now active
                pulse_left <= pulse_width - 7'h01;
            end else if (HORIZ_LINE_PULSE) begin
                if (pulse_left == 7'h00) begin
                    HORIZ_LINE_PULSE <= 1'b0;
                end else begin
                    pulse_left <= pulse_left - 7'h01;
                end
            end
        end
    end

    // weights of 1 to 5 binomial taps; results truncate toward zero
    function [7:0] binom;
        input [2:0] n;
        input [7:0] a;
        input [7:0] b;
        input [7:0] c;
        input [7:0] d;
        input [7:0] e;
        reg [11:0] s;
        begin
            s = 12'h000;
            case (n)
                3'd2: s = ({4'h0, a} + {4'h0, b}) >> 1;
                3'd3: s = ({4'h0, a} + {3'h0, b, 1'b0} + {4'h0, c}) >> 2;
                3'd4: s = ({4'h0, a} + 12'h003 * {4'h0, b} + 12'h003 * {4'h0, c} + {4'h0, d}) >> 3;
                3'd5: s = ({4'h0, a} + {2'h0, b, 2'h0} + 12'h006 * {4'h0, c} + {2'h0, d, 2'h0}
                    + {4'h0, e}) >> 4;
                default: s = {4'h0, a};
            endcase
            binom = s[7:0];
        end
    endfunction

    function [7:0] vfilter;
        input comb;
        input [1:0] code;
        input [3:0] ph;
        input [7:0] a;
        input [7:0] b;
        input [7:0] c;
        input [7:0] d;
        input [7:0] e;
        reg [2:0] n;
        reg [7:0] p;
        reg [7:0] q;
        reg [12:0] mix;
        begin
            n = 3'd1;
            p = 8'h00;
            q = 8'h00;
            mix = 13'h0000;
            if (comb) begin
                vfilter = binom({1'b0, code} + 3'd2, a, b, c, d, e);
            end else begin
                // code 00 is pure interpolation; others prefilter both interpolation lines
                n = (code == 2'b00) ? 3'd1 : {1'b0, code} + 3'd1;
                p = binom(n, a, b, c, d, 8'h00);
                q = binom(n, b, c, d, e, 8'h00);
                // older line weighs phase/16, newer line the rest
                mix = {5'h00, p} * (13'h0010 - {9'h000, ph}) + {5'h00, q} * {9'h000, ph};
                vfilter = mix[11:4];
            end
        end
    endfunction

    // lines from an earlier field are kept out from the pixel clock after a field change: missing taps repeat the oldest valid one
    assign t0 = PIX_DATA;
    assign t1 = (lines_seen > 3'd0) ? lb0[col] : t0;
    assign t2 = (lines_seen > 3'd1) ? lb1[col] : t1;
    assign t3 = (lines_seen > 3'd2) ? lb2[col] : t2;
    assign t4 = (lines_seen > 3'd3) ? lb3[col] : t3;
    assign filtered = vfilter(vert_comb_select, vert_tap_select, VERT_PHASE, t0, t1, t2, t3, t4);

    // column and line bookkeeping; field change flushes the line history
    always @(posedge CLOCK) begin
        if (!NRST) begin
            col <= 10'h000;
            lines_seen <= 3'd0;
            field_last <= 1'b0;
        end else if (pixel_clock_single) begin
            field_last <= FIELD_ODD;
            if (FIELD_ODD != field_last) begin
                lines_seen <= 3'd0;
                col <= 10'h000;
            end else if (LINE_START) begin
                col <= 10'h000;
                if (col != 10'h000 && lines_seen != 3'd4) begin
                    lines_seen <= lines_seen + 3'd1;
                end
            end else if (PIX_VALID) begin
                col <= col + 10'h001;
            end
        end
    end

    // shift the column down the line buffers as the new pixel arrives
    // no reset here: lines_seen keeps stale columns out of the taps
    always @(posedge CLOCK) begin
        if (pixel_clock_single && PIX_VALID && !LINE_START) begin
            lb0[col] <= PIX_DATA;
            lb1[col] <= lb0[col];
            lb2[col] <= lb1[col];
            lb3[col] <= lb2[col];
        end
    end

    always @(posedge CLOCK) begin
        if (!NRST) begin
            OUT_VALID <= 1'b0;
            OUT_DATA <= 8'h00;
        end else begin
            OUT_VALID <= pixel_clock_single && PIX_VALID && !LINE_START;
            if (pixel_clock_single && PIX_VALID && !LINE_START) begin
                OUT_DATA <= filtered;
            end
        end
    end

endmodule
`default_nettype wire

// *** vftc_map.vh ***
// register map, field positions, reset values and timing counts of the vertical filter timing block
`ifndef VFTC_MAP_VH
`define VFTC_MAP_VH

`define VFTC_ADDR_W 12
`define VFTC_OFS_EVEN_SCALE_UPPER 12'h04c
`define VFTC_OFS_EVEN_TIMING_CTL 12'h06c
`define VFTC_OFS_VARIANT_CFG 12'h070
`define VFTC_OFS_STATUS 12'h074
`define VFTC_OFS_SOFT_RESET_CMD 12'h07c
`define VFTC_OFS_ODD_SCALE_UPPER 12'h0cc
`define VFTC_OFS_ODD_TIMING_CTL 12'h0ec

`define VFTC_TC_PULSE_SEL_BIT 7
`define VFTC_TC_TAP_MSB 1
`define VFTC_TC_TAP_LSB 0
`define VFTC_TC_RESET 8'h00
`define VFTC_TC_WMASK 8'h83

`define VFTC_SU_COMB_BIT 6
`define VFTC_SU_SCALE_MSB 4
`define VFTC_SU_RESET 8'h00
`define VFTC_SU_WMASK 8'h5f

`define VFTC_VAR_LATER_BIT 0
`define VFTC_VAR_RESET 8'h00

`define VFTC_ST_PULSE_BIT 0
`define VFTC_ST_FIELD_BIT 1
`define VFTC_ST_COMB_BIT 2
`define VFTC_ST_TAP_LSB 4
`define VFTC_ST_LINES_LSB 8

`define VFTC_PULSE_LONG 7'h40
`define VFTC_PULSE_MID 7'h20
`define VFTC_PULSE_SHORT 7'h01

`define VFTC_LINE_DEPTH 1024
`define VFTC_COL_W 10

`endif

// *** vftc_sources_note_unused.v ***
// empty unit: the whole block lives in vftc_top.v
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// *** vftc_top_asserts.sv ***
// port checker for the vertical filter timing block
`timescale 1ns/1ps
`default_nettype none
module vftc_chk (
    input wire logic CLOCK,
    input wire logic NRST,
    input wire logic HSEL,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic HREADY,
    input wire logic [31:0] HRDATA,
    input wire logic HREADYOUT,
    input wire logic HRESP,
    input wire logic PIXEL_CE,
    input wire logic LINE_START,
    input wire logic PIX_VALID,
    input wire logic OUT_VALID,
    input wire logic [7:0] OUT_DATA,
    input wire logic HORIZ_LINE_PULSE
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!NRST);
    sequence s_start; PIXEL_CE && LINE_START; endsequence
    sequence s_take; PIXEL_CE && PIX_VALID && !LINE_START; endsequence
    // counts enabled pixel clocks the pulse has stood; restarted by a new line start
    logic [6:0] cnt;
    always_ff @(posedge CLOCK) begin
        if (!NRST || !HORIZ_LINE_PULSE || (PIXEL_CE && LINE_START)) cnt <= 7'h00;
        else if (PIXEL_CE) cnt <= cnt + 7'h01;
    end
    a_bus_okay: assert property (HREADYOUT && !HRESP) else $error("bus not ready or not okay");
    a_pulse_start: assert property (s_start |=> HORIZ_LINE_PULSE) else $error("pulse did not start");
    a_pulse_bound: assert property (cnt <= 7'h40) else $error("pulse too long");
    a_pix_answer: assert property (s_take |=> OUT_VALID) else $error("pixel not answered");
    a_out_cause: assert property (OUT_VALID |-> $past(PIXEL_CE) && $past(PIX_VALID) && !$past(LINE_START))
        else $error("output without pixel");
    a_out_hold: assert property ($changed(OUT_DATA) |-> OUT_VALID) else $error("output data moved");
    a_rd_hold: assert property ($changed(HRDATA) |-> $past(HSEL) && $past(HTRANS[1]) && !$past(HWRITE))
        else $error("read data moved without read");
    a_rd_upper: assert property (HRDATA[31:11] == 21'h00_0000) else $error("read upper bits set");
endmodule
`default_nettype wire

// *** test_vertical_filter_timing_ctl.sv ***
// self-checking bench for the vertical filter timing block
`timescale 1ns/1ps
`default_nettype none
module test_vertical_filter_timing_ctl;
    logic CLOCK = 0, NRST = 0, HSEL = 0, HWRITE = 0, PIXEL_CE = 1, FIELD_ODD = 0;
    logic LINE_START = 0, PIX_VALID = 0, OUT_VALID, HORIZ_LINE_PULSE, HREADYOUT, HRESP;
    logic [31:0] HADDR = 0, HWDATA = 0, HRDATA;
    logic [1:0] HTRANS = 0;
    logic [2:0] HSIZE = 3'h2;
    logic [7:0] PIX_DATA = 0, OUT_DATA;
    logic [3:0] VERT_PHASE = 4'h4;
    wire HREADY = HREADYOUT;
    int fails = 0, compares = 0;
    vftc_top dut_u (
        .CLOCK(CLOCK), .NRST(NRST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
        .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
        .HRESP(HRESP), .PIXEL_CE(PIXEL_CE), .FIELD_ODD(FIELD_ODD), .LINE_START(LINE_START),
        .PIX_VALID(PIX_VALID), .PIX_DATA(PIX_DATA), .VERT_PHASE(VERT_PHASE), .OUT_VALID(OUT_VALID),
        .OUT_DATA(OUT_DATA), .HORIZ_LINE_PULSE(HORIZ_LINE_PULSE)
    );
    initial begin
        forever #2.5 CLOCK = ~CLOCK;
    end
    task give_verdict;
        if (fails == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task wait_rdy;
        int n;
        n = 0;
        @(posedge CLOCK);
        while (HREADY !== 1'b1) begin
            n++;
            if (n > 50) begin fails++; give_verdict(); end
            @(posedge CLOCK);
        end
    endtask
    task bus(input logic w, input logic [11:0] a, input logic [7:0] d, output logic [31:0] r);
        HSEL <= 1'b1; HTRANS <= 2'h2; HWRITE <= w; HADDR <= {20'h0_0000, a};
        wait_rdy();
        HSEL <= 1'b0; HTRANS <= 2'h0; HWDATA <= {24'h00_0000, d};
        wait_rdy();
        r = HRDATA;
    endtask
    task wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask
    task rd_chk(input logic [11:0] a, input logic [7:0] e);
        logic [31:0] r;
        bus(1'b0, a, 8'h00, r);
        check("register read", r, {24'h00_0000, e});
    endtask
    // pulse is sampled on falling edges so the count never races the launching edge
    task pulse_chk(input logic odd, input logic [7:0] w);
        logic [7:0] n;
        FIELD_ODD <= odd; PIXEL_CE <= 1'b1;
        @(posedge CLOCK);
        LINE_START <= 1'b1;
        @(posedge CLOCK);
        LINE_START <= 1'b0;
        n = 0;
        @(negedge CLOCK);
        while (HORIZ_LINE_PULSE === 1'b1 && n < 8'hc8) begin n++; @(negedge CLOCK); end
        if (n == 8'hc8) begin fails++; give_verdict(); end
        @(posedge CLOCK);
        check("pulse width", n, w);
    endtask
    task line(input logic [7:0] px, output logic [7:0] o);
        PIXEL_CE <= 1'b1; LINE_START <= 1'b1;
        @(posedge CLOCK);
        LINE_START <= 1'b0; PIX_VALID <= 1'b1; PIX_DATA <= px;
        @(posedge CLOCK);
        PIX_VALID <= 1'b0; PIXEL_CE <= 1'b0;
        @(negedge CLOCK);
        o = OUT_DATA;
        @(posedge CLOCK);
    endtask
    // newest line 50 over older 100; absent older lines repeat 100
    task filt(input logic comb, input logic [1:0] code);
        int n, p, e;
        logic [7:0] o;
        wr(12'h04c, {1'b0, comb, 6'h00});
        wr(12'h06c, {6'h00, code});
        FIELD_ODD <= 1'b1; PIXEL_CE <= 1'b1;
        @(posedge CLOCK);
        FIELD_ODD <= 1'b0;
        @(posedge CLOCK);
        line(8'h64, o);
        check("first line", o, 32'h0000_0064);
        line(8'h32, o);
        n = comb ? code + 2 : (code == 0 ? 1 : code + 1);
        p = (50 + ((1 << (n - 1)) - 1) * 100) >> (n - 1);
        e = comb ? p : (p * 12 + 400) >> 4;
        check("filter out", o, e);
    endtask
    initial begin
        logic [31:0] r;
        repeat (20) @(posedge CLOCK);
        NRST <= 1'b1;
        @(posedge CLOCK);
        rd_chk(12'h06c, 8'h00);
        rd_chk(12'h0ec, 8'h00);
        rd_chk(12'h300, 8'h00);
        wr(12'h06c, 8'h03);
        wr(12'h0ec, 8'h81);
        rd_chk(12'h06c, 8'h03);
        rd_chk(12'h0ec, 8'h81);
        pulse_chk(1'b0, 8'h40);
        pulse_chk(1'b1, 8'h01);
        wr(12'h070, 8'h01);
        pulse_chk(1'b1, 8'h20);
        // single-pixel lines keep every tap code inside the width limits
        for (int i = 0; i < 8; i++) filt(i[2], i[1:0]);
        bus(1'b0, 12'h074, 8'h00, r);
        check("status", r, 32'h0000_0135);
        wr(12'h0cc, 8'hff);
        rd_chk(12'h0cc, 8'h5f);
        PIXEL_CE <= 1'b1; LINE_START <= 1'b1;
        @(posedge CLOCK);
        LINE_START <= 1'b0;
        wr(12'h07c, 8'h5a);
        bus(1'b0, 12'h07c, 8'h00, r);
        rd_chk(12'h06c, 8'h00);
        rd_chk(12'h04c, 8'h00);
        rd_chk(12'h070, 8'h00);
        rd_chk(12'h0ec, 8'h00);
        rd_chk(12'h0cc, 8'h00);
        give_verdict();
    end
endmodule
bind vftc_top vftc_chk chk_u (.CLOCK(CLOCK), .NRST(NRST), .HSEL(HSEL), .HTRANS(HTRANS), .HWRITE(HWRITE),
    .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .PIXEL_CE(PIXEL_CE),
    .LINE_START(LINE_START), .PIX_VALID(PIX_VALID), .OUT_VALID(OUT_VALID), .OUT_DATA(OUT_DATA),
    .HORIZ_LINE_PULSE(HORIZ_LINE_PULSE));
`default_nettype wire
